// *** core/sarc_ctrl.sv ***
// sarc_ctrl.sv : standby release and system reset control
// assumes: one 100 MHz clock, async reset from the supply domain,
//          interrupt flags and detectors on this clock, reset pin async
//
// Contract
// - pending unmasked interrupt leaves standby immediately
// - stop release holds 34 us before run
// - resonator adds selected oscillation wait
// - any reset halts main and low-speed oscillators
// - input-only pin low still resets before reread
// - pin-held reset lasts while pin stays low
// - low-voltage detector ignores its own reset
// - watchdog reset also reinitialises the watchdog
// - power-on-clear reset clears reset-cause flags
`timescale 1ns/10ps
`include "sarc_map.svh"
module sarc_ctrl
  import sarc_pkg::*;
#(
  parameter int RESTART_CYC = `SARC_RESTART_CYC,  // restart delay
  parameter int PIN_MIN_CYC = `SARC_PIN_MIN_CYC,  // least accepted low
  parameter int IRQ_N       = 8,                  // interrupt sources
  parameter int WAIT_W      = 16                  // oscillation wait width
) (
  input  wire logic              clk,
  input  wire logic              rst,                     // power-on-clear reset
  input  wire logic              reset_pin_n,             // external reset pin, async
  input  wire logic              pin_is_port,             // pin set as input-only port
  input  wire logic              option_reread,           // pulse: option byte re-read done
  input  wire logic              lvd_reset_req,           // low-voltage detector request
  input  wire logic              wdt_reset_req,           // watchdog overflow request
  input  wire logic [IRQ_N-1:0]  interrupt_request_flags, // pending requests
  input  wire logic [IRQ_N-1:0]  interrupt_mask_flags,    // 1 = masked
  input  wire logic              halt_req,                // pulse: enter halt
  input  wire logic              stop_req,                // pulse: enter stop
  input  wire logic              resonator_clk,           // crystal/ceramic source
  input  wire logic [WAIT_W-1:0] oscillation_wait_select, // wait in cycles
  input  wire logic              cause_read,              // byte read strobe
  output logic                   sys_reset,               // merged system reset
  output logic                   wdt_reset,               // watchdog reinit
  output logic                   lvd_logic_reset,         // resets detector state
  output logic                   main_osc_en,             // main oscillator run
  output logic                   lowspeed_osc_en,         // low-speed oscillator run
  output logic                   cpu_run,                 // core executes
  output logic [2:0]             standby_state,           // current standby state
  output sarc_byte_t             reset_cause_flags,       // cause byte
  output sarc_byte_t             cause_rdata              // byte read data
);

  // -----------------------------------------------------------------
  // pin synchronisation
  // -----------------------------------------------------------------
  logic pin_n_s;  // synchronised pin level

  sarc_sync #(.RST_VAL(1'b1)) u_pin_sync (
    .clk (clk),
    .rst (rst),
    .d   (reset_pin_n),
    .q   (pin_n_s)
  );

  // -----------------------------------------------------------------
  // pin low filter: pulses shorter than the least time are rejected
  // -----------------------------------------------------------------
  localparam int PC_W = $clog2(PIN_MIN_CYC + 1);
  logic [PC_W-1:0] pin_cnt_ff;   // low cycles seen
  logic            pin_rst_ff;   // accepted pin reset, held while low
  logic            port_arm_ff;  // port pin still resets until re-read
  logic            pin_active;   // pin is a reset source now

  // pin counts as reset in reset-pin mode or while the port is armed
  assign pin_active = !pin_is_port || port_arm_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_cnt_ff <= '0;
    end else if (pin_n_s || !pin_active) begin
      pin_cnt_ff <= '0;
    end else if (pin_cnt_ff != PC_W'(PIN_MIN_CYC)) begin
      pin_cnt_ff <= pin_cnt_ff + PC_W'(1);
    end
  end

  // once accepted, hold until pin returns high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_rst_ff <= 1'b0;
    end else if (pin_n_s) begin
      pin_rst_ff <= 1'b0;
    end else if (pin_active && pin_cnt_ff == PC_W'(PIN_MIN_CYC)) begin
      pin_rst_ff <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // port arming: set after an internal reset, cleared by re-read
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_arm_ff <= 1'b1;  // power-on-clear release arms it
    end else if (lvd_reset_req || wdt_reset_req) begin
      port_arm_ff <= 1'b1;
    end else if (option_reread) begin
      port_arm_ff <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // merged reset, registered so it is glitch free
  // -----------------------------------------------------------------
  logic sys_rst_ff;  // merged system reset
  logic wdt_rst_ff;  // watchdog self reinit

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_rst_ff <= 1'b1;
    end else begin
      sys_rst_ff <= pin_rst_ff || lvd_reset_req || wdt_reset_req;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_rst_ff <= 1'b1;
    end else begin
      wdt_rst_ff <= sys_rst_ff || pin_rst_ff || lvd_reset_req || wdt_reset_req;
    end
  end

  assign sys_reset = sys_rst_ff;
  assign wdt_reset = wdt_rst_ff;
  // detector state only cleared by power-on-clear, never by its own request
  assign lvd_logic_reset = rst;

  // -----------------------------------------------------------------
  // reset-cause flags: sticky, cleared by power-on-clear only
  // -----------------------------------------------------------------
  sarc_byte_t cause_ff;  // cause byte

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_ff <= `SARC_CAUSE_RST;
    end else begin
      if (pin_rst_ff)    cause_ff[`SARC_CAUSE_PIN] <= 1'b1;
      if (lvd_reset_req) cause_ff[`SARC_CAUSE_LVD] <= 1'b1;
      if (wdt_reset_req) cause_ff[`SARC_CAUSE_WDT] <= 1'b1;
    end
  end

  // whole byte captured per read; no bit access path exists
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cause_rdata <= `SARC_CAUSE_RST;
    end else if (cause_read) begin
      cause_rdata <= cause_ff;
    end
  end

  assign reset_cause_flags = cause_ff;

  // -----------------------------------------------------------------
  // standby state machine
  // -----------------------------------------------------------------
  localparam int RC_W = $clog2(RESTART_CYC + 1);
  sarc_state_e       st_ff;      // state
  sarc_state_e       nxt_st;     // next state
  logic [RC_W-1:0]   rs_cnt_ff;  // restart countdown
  logic [WAIT_W-1:0] ow_cnt_ff;  // oscillation wait countdown
  logic              wake;       // unmasked request pending

  assign wake = |(interrupt_request_flags & ~interrupt_mask_flags);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      SARC_RUN: begin
        if (stop_req && !wake)      nxt_st = SARC_STOP;   // immediate release if pending
        else if (halt_req && !wake) nxt_st = SARC_HALT;
      end
      SARC_HALT: begin
        if (wake) nxt_st = SARC_RUN;
      end
      SARC_STOP: begin
        if (wake) nxt_st = SARC_RESTART;
      end
      SARC_RESTART: begin
        if (rs_cnt_ff == '0) begin
          nxt_st = (resonator_clk && oscillation_wait_select != '0) ? SARC_OSCWAIT : SARC_RUN;
        end
      end
      SARC_OSCWAIT: begin
        if (ow_cnt_ff == '0) nxt_st = SARC_RUN;
      end
      default: nxt_st = SARC_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= SARC_RUN;
    end else if (sys_rst_ff) begin
      st_ff <= SARC_RUN;  // reset leaves standby
    end else begin
      st_ff <= nxt_st;
    end
  end

  // restart delay loaded on leaving stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rs_cnt_ff <= '0;
    end else if (st_ff == SARC_STOP) begin
      rs_cnt_ff <= RC_W'(RESTART_CYC - 1);
    end else if (st_ff == SARC_RESTART && rs_cnt_ff != '0) begin
      rs_cnt_ff <= rs_cnt_ff - RC_W'(1);
    end
  end

  // oscillation wait loaded during restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ow_cnt_ff <= '0;
    end else if (st_ff == SARC_RESTART) begin
      ow_cnt_ff <= oscillation_wait_select - WAIT_W'(1);
    end else if (st_ff == SARC_OSCWAIT && ow_cnt_ff != '0) begin
      ow_cnt_ff <= ow_cnt_ff - WAIT_W'(1);
    end
  end

  // -----------------------------------------------------------------
  // oscillator enables and core run
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      main_osc_en     <= 1'b0;
      lowspeed_osc_en <= 1'b0;
    end else begin
      main_osc_en     <= !sys_rst_ff && nxt_st != SARC_STOP;
      lowspeed_osc_en <= !sys_rst_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_run <= 1'b0;
    end else begin
      cpu_run <= !sys_rst_ff && nxt_st == SARC_RUN;
    end
  end

  assign standby_state = st_ff;
endmodule : sarc_ctrl

// *** core/sarc_map.svh ***
// sarc_map.svh : field positions, reset values and timing counts
// assumes: included by the standby/reset controller files only
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH

// -----------------------------------------------------------------
// timing figures and derived cycle counts (clock 100 MHz)
// -----------------------------------------------------------------
`define SARC_CLK_MHZ          100
`define SARC_RESTART_US       34
`define SARC_RESTART_CYC      (`SARC_RESTART_US * `SARC_CLK_MHZ)
`define SARC_PIN_MIN_US       2
`define SARC_PIN_MIN_CYC      (`SARC_PIN_MIN_US * `SARC_CLK_MHZ)

// -----------------------------------------------------------------
// reset-cause flag layout and reset values
// -----------------------------------------------------------------
`define SARC_CAUSE_PIN        0
`define SARC_CAUSE_LVD        1
`define SARC_CAUSE_WDT        2
`define SARC_CAUSE_RST        8'h00

`endif

// *** core/sarc_pkg.sv ***
// sarc_pkg.sv : types of the standby and reset controller
// assumes: compiled before the controller modules
package sarc_pkg;
  // standby state; run->halt, stop->restart->wait and restart->run change one bit, run->stop and wait->run change two
  typedef enum logic [2:0] {
    SARC_RUN     = 3'b000,
    SARC_HALT    = 3'b001,
    SARC_STOP    = 3'b011,
    SARC_RESTART = 3'b010,
    SARC_OSCWAIT = 3'b110
  } sarc_state_e;

  typedef logic [7:0] sarc_byte_t;
endpackage : sarc_pkg

// *** core/sarc_sync.sv ***
// sarc_sync.sv : two flip-flop synchroniser for one pin level
// assumes: single clock, async active-high reset
`timescale 1ns/10ps
module sarc_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  // -----------------------------------------------------------------
  // two stages; first stage is read by the second only
  // -----------------------------------------------------------------
  logic meta_ff;  // first stage

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : sarc_sync

// *** tb/sarc_chk.sv ***
// sarc_chk.sv : port assertions for the standby/reset controller
// assumes: bound to sarc_ctrl, one clock domain, async reset rst
`timescale 1ns/10ps
module sarc_chk
  import sarc_pkg::*;
#(
  parameter int RESTART_CYC = 10,
  parameter int PIN_MIN_CYC = 4,
  parameter int IRQ_N       = 8,
  parameter int WAIT_W      = 16
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              reset_pin_n,
  input wire logic              pin_is_port,
  input wire logic              lvd_reset_req,
  input wire logic              wdt_reset_req,
  input wire logic [IRQ_N-1:0]  interrupt_request_flags,
  input wire logic [IRQ_N-1:0]  interrupt_mask_flags,
  input wire logic              resonator_clk,
  input wire logic [WAIT_W-1:0] oscillation_wait_select,
  input wire logic              sys_reset,
  input wire logic              wdt_reset,
  input wire logic              lvd_logic_reset,
  input wire logic              main_osc_en,
  input wire logic              lowspeed_osc_en,
  input wire logic              cpu_run,
  input wire logic [2:0]        standby_state,
  input wire sarc_byte_t        reset_cause_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] rcnt_ff; // cycles spent in restart
  logic [15:0] pcnt_ff; // consecutive low pin samples
  logic        wake;    // unmasked pending request
  assign wake = |(interrupt_request_flags & ~interrupt_mask_flags);
  // restart length counter, cleared on leaving restart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rcnt_ff <= '0;
    else rcnt_ff <= (standby_state == 3'b010) ? rcnt_ff + 16'h1 : '0;
  end
  // pin low length; slack of six covers sync and filter stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pcnt_ff <= '0;
    else pcnt_ff <= reset_pin_n ? '0 : pcnt_ff + 16'h1;
  end
  a_halt_wake: assert property (standby_state == 3'b001 && wake |=> standby_state == 3'b000)
    else $error("halt not left on wake");
  a_stop_wake: assert property (standby_state == 3'b011 && wake && !sys_reset |=> standby_state == 3'b010)
    else $error("stop not left on wake");
  a_restart_len: assert property (standby_state != 3'b010 && rcnt_ff != 0 && !wdt_reset |-> rcnt_ff == 16'(RESTART_CYC))
    else $error("restart length wrong");
  a_restart_idle: assert property (standby_state == 3'b010 |-> !cpu_run)
    else $error("core runs during restart");
  a_osc_wait: assert property (standby_state == 3'b010 && resonator_clk && oscillation_wait_select != 0 && !sys_reset
    ##1 standby_state != 3'b010 |-> standby_state == 3'b110) else $error("oscillation wait skipped");
  a_reset_osc: assert property (sys_reset |=> !main_osc_en && !lowspeed_osc_en)
    else $error("oscillators run in reset");
  a_pin_hold: assert property (!pin_is_port && pcnt_ff == 16'(PIN_MIN_CYC + 6) |-> sys_reset)
    else $error("long pin low gave no reset");
  a_lvd_keep: assert property (lvd_reset_req ##1 sys_reset |-> !lvd_logic_reset[*3])
    else $error("detector reset by own request");
  a_wdt_reinit: assert property (wdt_reset_req |=> wdt_reset && sys_reset && reset_cause_flags[2])
    else $error("watchdog not reinitialised");
  a_merge_lvd: assert property (lvd_reset_req |=> sys_reset && reset_cause_flags[1])
    else $error("detector request not merged");
endmodule : sarc_chk

// *** tb/sarc_ctrl_test.sv ***
// sarc_ctrl_test.sv : directed bench for the standby/reset controller
// assumes: short counts (restart 10, pin filter 4) to keep runs brief
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module sarc_ctrl_test;
  import sarc_pkg::*;
  logic clk = 1'b0;  // of the bench-driven stimulus only the clock starts from a declared value; the rest is set by the sequence
  logic rst, pin_is_port, option_reread, halt_req, stop_req;
  logic resonator_clk, cause_read, reset_pin_n, lvd_reset_req, wdt_reset_req;
  logic [7:0] interrupt_request_flags, interrupt_mask_flags;
  logic [15:0] oscillation_wait_select;
  logic sys_reset, wdt_reset, lvd_logic_reset, main_osc_en, lowspeed_osc_en, cpu_run;
  logic [2:0] standby_state;
  sarc_byte_t reset_cause_flags, cause_rdata;
  int err_total = 0, num_checks = 0, cycles = 0;
  always #5 clk = ~clk;
  sarc_src_model i_src (.clk, .reset_pin_n, .lvd_reset_req, .wdt_reset_req);
  sarc_ctrl #(.RESTART_CYC(10), .PIN_MIN_CYC(4)) i_dut (.clk, .rst, .reset_pin_n, .pin_is_port,
    .option_reread, .lvd_reset_req, .wdt_reset_req, .interrupt_request_flags, .interrupt_mask_flags,
    .halt_req, .stop_req, .resonator_clk, .oscillation_wait_select, .cause_read, .sys_reset,
    .wdt_reset, .lvd_logic_reset, .main_osc_en, .lowspeed_osc_en, .cpu_run, .standby_state,
    .reset_cause_flags, .cause_rdata);
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // hang guard, far above the directed sequence length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    rst <= 1'b1; pin_is_port <= 1'b0; option_reread <= 1'b0; halt_req <= 1'b0; stop_req <= 1'b0;
    resonator_clk <= 1'b0; cause_read <= 1'b0; interrupt_request_flags <= 8'h00; interrupt_mask_flags <= 8'h00;
    oscillation_wait_select <= 16'h0000;
    step(10); rst <= 0; step(3); @(negedge clk);
    `CHK("cause after por", 8'h00, reset_cause_flags);
    `CHK("osc running", 2'b11, {main_osc_en, lowspeed_osc_en});
    // masked request must not wake halt
    step(1); interrupt_request_flags <= 8'h10; interrupt_mask_flags <= 8'h10; halt_req <= 1;
    step(1); halt_req <= 0; step(3); @(negedge clk);
    `CHK("halt masked", 3'b001, standby_state);
    step(1); interrupt_mask_flags <= 8'h00; step(3); @(negedge clk);
    `CHK("halt woken", 1'b1, cpu_run);
    step(1); stop_req <= 1; step(1); stop_req <= 0; step(2); @(negedge clk);
    `CHK("stop refused", 3'b000, standby_state);
    // stop, wake, restart delay then resonator wait of five
    step(1); interrupt_request_flags <= 0; resonator_clk <= 1; oscillation_wait_select <= 16'h0005;
    stop_req <= 1; step(1); stop_req <= 0; step(3); @(negedge clk);
    `CHK("in stop", 3'b011, standby_state);
    step(1); interrupt_request_flags <= 8'h01; step(8); @(negedge clk);
    `CHK("restart", 4'b0100, {standby_state, cpu_run});
    step(6); @(negedge clk);
    `CHK("osc wait", 3'b110, standby_state);
    step(6); @(negedge clk);
    `CHK("resumed", 1'b1, cpu_run);
    step(1); interrupt_request_flags <= 0;
    // rc clock: restart delay only, no oscillation wait even with a wait selected
    step(1); resonator_clk <= 0; stop_req <= 1; step(1); stop_req <= 0; interrupt_request_flags <= 8'h02;
    step(12); @(negedge clk);
    `CHK("no osc wait", 1'b1, cpu_run);
    step(1); interrupt_request_flags <= 0;
    // pin resets: short low refused, long low held
    i_src.pin_low(2); step(6); @(negedge clk);
    `CHK("short pin", 1'b0, sys_reset);
    fork i_src.pin_low(20); begin step(15); @(negedge clk); `CHK("pin held", 1'b1, sys_reset); end join
    step(6); @(negedge clk);
    `CHK("pin released", 1'b0, sys_reset);
    `CHK("pin cause", 8'h01, reset_cause_flags);
    step(1); cause_read <= 1; step(1); cause_read <= 0; step(1); @(negedge clk);
    `CHK("cause byte", 8'h01, cause_rdata);
    i_src.req(1, 2); step(4); @(negedge clk);
    `CHK("wdt cause", 8'h05, reset_cause_flags);
    fork i_src.req(0, 6); begin step(3); @(negedge clk);
      `CHK("lvd merged", 3'b100, {sys_reset, lowspeed_osc_en, lvd_logic_reset}); end join
    step(6); @(negedge clk);
    `CHK("lvd cause", 8'h07, reset_cause_flags);
    // port mode: armed after detector reset, disarmed by reread
    step(1); pin_is_port <= 1;
    fork i_src.pin_low(20); begin step(15); @(negedge clk); `CHK("port armed", 1'b1, sys_reset); end join
    step(6); option_reread <= 1; step(1); option_reread <= 0;
    fork i_src.pin_low(20); begin step(15); @(negedge clk); `CHK("port off", 1'b0, sys_reset); end join
    step(2); rst <= 1; step(2); rst <= 0; step(3); @(negedge clk);
    `CHK("cause cleared", 8'h00, reset_cause_flags);
    summarize();
  end
endmodule : sarc_ctrl_test
bind sarc_ctrl sarc_chk #(.RESTART_CYC(RESTART_CYC), .PIN_MIN_CYC(PIN_MIN_CYC), .IRQ_N(IRQ_N),
  .WAIT_W(WAIT_W)) i_chk (.clk, .rst, .reset_pin_n, .pin_is_port, .lvd_reset_req, .wdt_reset_req,
  .interrupt_request_flags, .interrupt_mask_flags, .resonator_clk, .oscillation_wait_select,
  .sys_reset, .wdt_reset, .lvd_logic_reset, .main_osc_en, .lowspeed_osc_en, .cpu_run,
  .standby_state, .reset_cause_flags);

// *** tb/sarc_src_model.sv ***
// sarc_src_model.sv : external reset pin driver and lvd/wdt sources
// assumes: tasks called by the bench; the pin has a pull-up
`timescale 1ns/10ps
module sarc_src_model (
  input  wire logic clk,
  output logic      reset_pin_n,
  output logic      lvd_reset_req,
  output logic      wdt_reset_req
);
  initial begin
    reset_pin_n = 1'b1;   // pulled up while nobody drives it
    lvd_reset_req = 1'b0;
    wdt_reset_req = 1'b0;
  end
  // pin low for n cycles; short n only when a refusal is wanted
  task automatic pin_low(input int n);
    @(posedge clk) reset_pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    reset_pin_n <= 1'b1;
  endtask : pin_low
  // level request, 0 = detector, 1 = watchdog
  task automatic req(input bit wdt, input int n);
    @(posedge clk);
    if (wdt) wdt_reset_req <= 1'b1;
    else lvd_reset_req <= 1'b1;
    repeat (n) @(posedge clk);
    wdt_reset_req <= 1'b0;
    lvd_reset_req <= 1'b0;
  endtask : req
endmodule : sarc_src_model
